// *** src/dac_front_pkg.sv ***
// Purpose: Shared constants and types for the DAC serial load and clear front end.
// Assumes: One 10 MHz system clock; serial pins are sampled, not used as clocks.
// Notes:   Frame layout, register offsets and reset values live here only.
// Operation
// - Serial input bits shift in on each falling serial clock edge while frame select is low.
// - With load held low, a write updates the addressed output register when the frame ends.
// - With load high during a write, only the addressed input register is updated.
// - A falling load edge copies pending input registers into all output registers at once.
// - A rising clear edge drives outputs to the preprogrammed clear code.
// - Clear forces only channels whose clear enable is set; others keep their codes.
// - While clear is high, no frame end or load edge may write the output registers.
// - In readback, the serial register shifts out on serial out, clocked by the serial clock.
package dac_front_pkg;

  // ************************************************************
  // Sizes and frame layout
  // ************************************************************
  localparam int          NUM_CH      = 4;
  localparam int          CODE_W      = 16;
  localparam int          FRAME_BITS  = 24;
  localparam int          ADDR_HI     = 23;
  localparam int          ADDR_LO     = 22;
  localparam int          READ_BIT    = 21;
  localparam int          CH_HI       = 17;
  localparam int          CH_LO       = 16;
  localparam logic [4:0]  FRAME_COUNT = 5'h18;

  // ************************************************************
  // Register map, byte addresses on the 32-bit bus
  // ************************************************************
  localparam logic [7:0]  OFS_CLR_EN   = 8'h00;
  localparam logic [7:0]  OFS_CLR_CODE = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_OUT_BASE = 8'h10;
  localparam logic [7:0]  OFS_IN_BASE  = 8'h20;
  localparam logic [3:0]  RST_CLR_EN   = 4'h0;
  localparam logic [15:0] RST_CLR_CODE = 16'h0000;
  localparam logic [15:0] RST_CODE     = 16'h0000;

  // ************************************************************
  // Pin bundle, one bit per pin, synchronised as a group
  // ************************************************************
  typedef struct packed {
    logic frameSelN;
    logic serialClk;
    logic serialIn;
    logic loadOutputsN;
    logic clearIn;
    logic boardAddrBit1;
    logic boardAddrBit0;
  } pins_t;

  localparam int PIN_W = $bits(pins_t);

endpackage

// *** src/dac_serial_load_clear_control.sv ***
// Purpose: Serial input, load and clear control for a quad 16-bit DAC.
// Assumes: Avalon-MM slave with waitrequest; serial pins asynchronous to clock.
// Notes:   Serial clock is oversampled, so it must be well below half the system clock.
//          Each serial clock phase must last at least two system clocks or it is lost.
//          Frames of the wrong length or for another board address are dropped whole.
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
module dac_serial_load_clear_control
  import dac_front_pkg::*;
(
  input  wire logic                           clock,
  input  wire logic                           sys_rst,
  input  wire logic                           frameSelN,
  input  wire logic                           serialClk,
  input  wire logic                           serialIn,
  input  wire logic                           loadOutputsN,
  input  wire logic                           clearIn,
  input  wire logic                           boardAddrBit0,
  input  wire logic                           boardAddrBit1,
  output logic                                serialOut,
  output logic [NUM_CH-1:0][CODE_W-1:0]       dacCode,
  input  wire logic [7:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  output logic [31:0]                         avs_readdata,
  output logic                                avs_waitrequest
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  pins_t pinsRaw;
  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] sync_ff;
  logic [PIN_W-1:0] prev_ff;
  pins_t pinsNow;
  pins_t pinsOld;

  assign pinsRaw = '{frameSelN, serialClk, serialIn, loadOutputsN, clearIn,
                     boardAddrBit1, boardAddrBit0};

  // All stages reset high, the idle level of the clock, select and load pins;
  // clearIn then reads high for two clocks, which only blocks output writes
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
          prev_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pinsRaw[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
    end
  endgenerate

  assign pinsNow = pins_t'(sync_ff);
  assign pinsOld = pins_t'(prev_ff);

  // Edges compare the synchronised level with its copy one clock older
  wire sclkFall  = pinsOld.serialClk & ~pinsNow.serialClk;
  wire inFrame   = ~pinsNow.frameSelN;
  wire frameEnd  = ~pinsOld.frameSelN & pinsNow.frameSelN;
  wire loadFall  = pinsOld.loadOutputsN & ~pinsNow.loadOutputsN;
  wire clearRise = ~pinsOld.clearIn & pinsNow.clearIn;
  wire clearHigh = pinsNow.clearIn;

  // ************************************************************
  // Input shifter and frame decode
  // ************************************************************
  logic [FRAME_BITS-1:0] shift_ff;
  logic [FRAME_BITS-1:0] nxt_shift;
  logic [4:0]            bitCnt_ff;
  logic [4:0]            nxt_bitCnt;

  always_comb begin
    nxt_shift  = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    if (inFrame && sclkFall) begin
      nxt_shift = {shift_ff[FRAME_BITS-2:0], pinsNow.serialIn};
      // Saturate so an over-long frame cannot wrap round to a valid length
      if (bitCnt_ff != 5'h1f) begin
        nxt_bitCnt = bitCnt_ff + 5'h01;
      end
    end else if (!inFrame && !frameEnd) begin
      nxt_bitCnt = 5'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shift_ff  <= '0;
      bitCnt_ff <= 5'h00;
    end else begin
      shift_ff  <= nxt_shift;
      bitCnt_ff <= nxt_bitCnt;
    end
  end

  // Frames of the wrong length are dropped rather than half-applied
  // Bits 20 to 18 of a frame carry nothing and are not checked
  wire [1:0] boardAddr = {pinsNow.boardAddrBit1, pinsNow.boardAddrBit0};
  wire addrHit   = shift_ff[ADDR_HI:ADDR_LO] == boardAddr;
  wire goodFrame = frameEnd && (bitCnt_ff == FRAME_COUNT) && addrHit;
  wire isRead    = shift_ff[READ_BIT];
  wire [1:0] frameCh = shift_ff[CH_HI:CH_LO];
  wire frameWrite = goodFrame && !isRead;
  wire frameRead  = goodFrame && isRead;

  // ************************************************************
  // Bus registers
  // ************************************************************
  logic [NUM_CH-1:0] clrEn_ff;
  logic [CODE_W-1:0] clrCode_ff;
  logic [NUM_CH-1:0][CODE_W-1:0] inReg_ff;
  logic [31:0]       readData_ff;
  logic              waitReq_ff;

  wire busReq    = avs_read | avs_write;
  wire busAccept = avs_write & ~waitReq_ff;
  wire [1:0] busCh = avs_address[3:2];
  // The per-channel windows need the two low address bits at zero
  wire hitEn     = avs_address == OFS_CLR_EN;
  wire hitCode   = avs_address == OFS_CLR_CODE;
  wire hitStat   = avs_address == OFS_STATUS;
  wire hitOut    = avs_address[7:4] == OFS_OUT_BASE[7:4] && avs_address[1:0] == 2'b00;
  wire hitIn     = avs_address[7:4] == OFS_IN_BASE[7:4] && avs_address[1:0] == 2'b00;

  // Status shows the synchronised pins, so it trails them by two clocks
  logic [31:0] rdMux;
  assign rdMux = hitEn   ? {28'h0000000, clrEn_ff} :
                 hitCode ? {16'h0000, clrCode_ff} :
                 hitStat ? {29'h00000000, clearHigh, pinsNow.loadOutputsN, inFrame} :
                 hitOut  ? {16'h0000, dacCode[busCh]} :
                 hitIn   ? {16'h0000, inReg_ff[busCh]} : 32'h00000000;

  // One wait state: waitrequest drops for a single cycle per request
  // A write lands on the clock at which the master sees waitrequest low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      waitReq_ff  <= 1'b1;
      readData_ff <= 32'h00000000;
      clrEn_ff    <= RST_CLR_EN;
      clrCode_ff  <= RST_CLR_CODE;
    end else begin
      waitReq_ff  <= ~(busReq & waitReq_ff);
      readData_ff <= (avs_read & waitReq_ff) ? rdMux : readData_ff;
      if (busAccept && hitEn) begin
        clrEn_ff <= avs_writedata[NUM_CH-1:0];
      end
      if (busAccept && hitCode) begin
        clrCode_ff <= avs_writedata[CODE_W-1:0];
      end
    end
  end

  assign avs_waitrequest = waitReq_ff;
  assign avs_readdata    = readData_ff;

  // ************************************************************
  // Per-channel input and output registers
  // ************************************************************
  // Output codes come only from frames, load edges and clear, never from the bus
  logic [NUM_CH-1:0][CODE_W-1:0] out_ff;

  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // A frame end and a load edge in one clock give the frame's code to its
      // channel; the load edge then has nothing newer to copy for it
      wire chWr     = frameWrite && (frameCh == 2'(gi));
      wire directUp = chWr && !pinsNow.loadOutputsN;
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          inReg_ff[gi] <= RST_CODE;
          out_ff[gi]   <= RST_CODE;
        end else begin
          if (chWr) begin
            inReg_ff[gi] <= shift_ff[CODE_W-1:0];
          end
          // Clear edge wins; clear level blocks every output write
          if (clearRise && clrEn_ff[gi]) begin
            out_ff[gi] <= clrCode_ff;
          end else if (clearHigh) begin
            out_ff[gi] <= out_ff[gi];
          end else if (directUp) begin
            out_ff[gi] <= shift_ff[CODE_W-1:0];
          end else if (loadFall) begin
            out_ff[gi] <= inReg_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign dacCode = out_ff;

  // ************************************************************
  // Readback shifter
  // ************************************************************
  logic [FRAME_BITS-1:0] rbShift_ff;
  logic                  serOut_ff;

  // A read frame loads the selected channel; the next frame shifts it out MSB first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rbShift_ff <= '0;
      serOut_ff  <= 1'b0;
    end else if (frameRead) begin
      // Serial out keeps its level here; it moves only on a serial clock fall
      rbShift_ff <= {8'h00, out_ff[frameCh]};
    end else if (inFrame && sclkFall) begin
      rbShift_ff <= {rbShift_ff[FRAME_BITS-2:0], 1'b0};
      serOut_ff  <= rbShift_ff[FRAME_BITS-1];
    end
  end

  assign serialOut = serOut_ff;

endmodule

// *** testbench/dac_front_props.sv ***
// Purpose: Port checks of the DAC serial load and clear front end.
// Assumes: Load, clear and frame select pulses last 8 clocks or more; serial clock phases last 4 or more.
// Notes:   Pin effects lag up to 4 clocks through the synchronisers.
module dac_front_props
  import dac_front_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        frameSelN,
  input wire logic        serialClk,
  input wire logic        loadOutputsN,
  input wire logic        clearIn,
  input wire logic        serialOut,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] dacCode,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Helper counters
  // ****************
  logic       clkQ, ldQ, clrQ, fsQ;
  logic [3:0] sinceFall, sinceCause, quietCnt, clrCnt;
  wire        fellClk = clkQ && !serialClk;
  wire        cause   = (!fsQ && frameSelN) || (ldQ && !loadOutputsN) || (!clrQ && clearIn);
  function automatic logic [3:0] inc(logic [3:0] v);
    return v + {3'h0, v != 4'hf};
  endfunction
  always_ff @(posedge clock) begin
    {clkQ, ldQ, clrQ, fsQ} <= sys_rst ? 4'hd : {serialClk, loadOutputsN, clearIn, frameSelN};
    sinceFall <= (sys_rst || !fellClk) ? (sys_rst ? 4'hf : inc(sinceFall)) : 4'h0;
    sinceCause <= (sys_rst || !cause) ? (sys_rst ? 4'hf : inc(sinceCause)) : 4'h0;
    quietCnt <= (sys_rst || !loadOutputsN || clearIn) ? 4'h0 : inc(quietCnt);
    clrCnt <= (sys_rst || !clearIn) ? 4'h0 : inc(clrCnt);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");
  a_reset_values: assert property (
    $fell(sys_rst) |-> avs_waitrequest && dacCode == '0 && !serialOut)
    else $error("outputs not at reset values");
  a_sdo_timing: assert property ($changed(serialOut) |-> sinceFall <= 4'h5)
    else $error("serial out moved without a serial clock fall");
  a_code_cause: assert property (
    $changed(dacCode) |-> sinceCause <= 4'h7)
    else $error("output code changed without a frame end, load or clear edge");
  a_quiet_hold: assert property (quietCnt >= 4'h8 |-> $stable(dacCode))
    else $error("output code changed while load was high");
  a_clear_block: assert property (clrCnt >= 4'h8 |-> $stable(dacCode))
    else $error("output code written while clear was high");
endmodule
bind dac_serial_load_clear_control dac_front_props u_props (
  .clock, .sys_rst, .frameSelN, .serialClk, .loadOutputsN, .clearIn, .serialOut,
  .dacCode, .avs_read, .avs_write, .avs_waitrequest
);

// *** testbench/host_serial_master.sv ***
// Purpose: Host serial master that sends 24-bit frames and captures readback.
// Assumes: Four system clocks per low serial clock phase; high phases within a frame last seven.
// Notes:   One stray serial clock pulse follows each frame; the data line toggles when idle.
module host_serial_master
  import dac_front_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   serialOut,
  output logic        frameSelN,
  output logic        serialClk,
  output logic        serialIn,
  output logic [23:0] rxWord
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {frameSelN, serialClk, serialIn, rxWord} = {3'h6, 24'h0};
  end
  task automatic send(input logic [FRAME_BITS-1:0] w);
    frameSelN <= 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      serialIn <= w[i];
      repeat (4) @(posedge clock);
      serialClk <= 1'b0;
      repeat (4) @(posedge clock);
      serialClk <= 1'b1;
      repeat (3) @(posedge clock);
      rxWord <= {rxWord[22:0], serialOut};
    end
    repeat (4) @(posedge clock);
    frameSelN <= 1'b1;
    serialIn <= ~serialIn;
    repeat (4) @(posedge clock);
    serialClk <= 1'b0;
    repeat (4) @(posedge clock);
    serialClk <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
endmodule

// *** testbench/tb_dac_serial_load_clear_control.sv ***
// Purpose: Self-checking bench for the DAC serial load and clear front end.
// Assumes: Pins idle after reset; host model keeps the serial clock slow.
// Notes:   Random codes from a fixed seed, corner cases inline.
module tb_dac_serial_load_clear_control
  import dac_front_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, sys_rst = 1, loadOutputsN = 1, clearIn = 0, avs_read = 0, avs_write = 0;
  logic frameSelN, serialClk, serialIn, serialOut, avs_waitrequest;
  logic [1:0] me, c;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [NUM_CH-1:0][CODE_W-1:0] dacCode;
  logic [23:0] rxWord;
  logic [15:0] expIn [4], expOut [4], clrCode;
  logic [3:0] clrEn;
  int n_errors = 0, compares = 0;
  always #50 clock = ~clock;
  dac_serial_load_clear_control u_dut (.clock, .sys_rst, .frameSelN, .serialClk, .serialIn,
    .loadOutputsN, .clearIn, .boardAddrBit0(me[0]), .boardAddrBit1(me[1]), .serialOut,
    .dacCode, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest);
  host_serial_master u_host (.clock, .serialOut, .frameSelN, .serialClk, .serialIn, .rxWord);
  function automatic logic [15:0] clrVal(int ch);
    return clrEn[ch] ? clrCode : expOut[ch];
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    int n = 0;
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    @(posedge clock);
    if (n >= 50) begin
      chk("waitrequest", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask
  task automatic frame(logic [1:0] a, logic rd, logic [1:0] ch, logic [15:0] code);
    u_host.send({a, rd, 3'h0, ch, code});
    repeat (8) @(posedge clock);
    if (a == me && !rd) begin
      expIn[ch] = code;
      if (!loadOutputsN && !clearIn) expOut[ch] = code;
    end
  endtask
  task automatic verify();
    for (int i = 0; i < NUM_CH; i++) begin
      bus(0, OFS_OUT_BASE + 8'(4 * i), 32'h0, q);
      chk("outReg", {16'h0, expOut[i]}, q);
      bus(0, OFS_IN_BASE + 8'(4 * i), 32'h0, q);
      chk("inReg", {16'h0, expIn[i]}, q);
      chk("dacCode", {16'h0, expOut[i]}, {16'h0, dacCode[i]});
    end
  endtask
  initial begin
    void'($urandom(23));
    me <= 2'(1 + $urandom % 3);
    foreach (expIn[i]) {expIn[i], expOut[i]} = 32'h0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    bus(1, 8'hfc, 32'hffffffff, q);
    bus(0, 8'hfc, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(0, OFS_STATUS, 32'h0, q);
    chk("statusIdle", 32'h2, q);
    bus(0, OFS_CLR_CODE, 32'h0, q);
    chk("clrCode", 32'(RST_CLR_CODE), q);
    bus(1, OFS_OUT_BASE, 32'h1234, q);
    verify();
    loadOutputsN <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      frame(i < 4 ? me : me ^ 2'(1 + $urandom % 3), 0, 2'($urandom), 16'($urandom));
    end
    verify();
    loadOutputsN <= 1'b1;
    for (int i = 0; i < 4; i++) frame(me, 0, 2'(i), 16'($urandom));
    verify();
    loadOutputsN <= 1'b0;
    repeat (8) @(posedge clock);
    foreach (expOut[i]) expOut[i] = expIn[i];
    verify();
    clrEn = (4'($urandom) | 4'h1) & 4'h7;
    clrCode = 16'($urandom);
    bus(1, OFS_CLR_EN, 32'(clrEn), q);
    bus(1, OFS_CLR_CODE, 32'(clrCode), q);
    bus(0, OFS_CLR_EN, 32'h0, q);
    chk("clrEn", 32'(clrEn), q);
    clearIn <= 1'b1;
    repeat (8) @(posedge clock);
    bus(0, OFS_STATUS, 32'h0, q);
    chk("statusClear", 32'h4, q);
    foreach (expOut[i]) expOut[i] = clrVal(i);
    verify();
    frame(me, 0, 2'h0, ~expOut[0]);
    loadOutputsN <= 1'b1;
    repeat (8) @(posedge clock);
    loadOutputsN <= 1'b0;
    repeat (8) @(posedge clock);
    verify();
    clearIn <= 1'b0;
    c = 2'($urandom);
    frame(me, 1, c, 16'h0);
    frame(me, 1, c, 16'h0);
    chk("readback", {8'h0, expOut[c]}, {8'h0, rxWord});
    tally_and_finish();
  end
endmodule
